// file: counter_array_pkg.sv
package counter_array_pkg;

    localparam int NUM_CH = 3;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_HOLD_CYCLES = 2;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_SETUP = 4'h1;
    localparam logic [3:0] ADDR_PWM = 4'h2;
    localparam logic [3:0] ADDR_CNT_LO = 4'h3;
    localparam logic [3:0] ADDR_CNT_HI = 4'h4;
    localparam logic [3:0] ADDR_MODE0 = 4'h5;
    localparam logic [3:0] ADDR_CMP0 = 4'h8;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODE_WIDE = 7;
    localparam int MODE_CMP_EN = 6;
    localparam int MODE_RISE = 5;
    localparam int MODE_FALL = 4;
    localparam int MODE_MATCH = 3;
    localparam int MODE_TOG = 2;
    localparam int MODE_PULSE = 1;
    localparam int MODE_IRQ = 0;
    localparam int CTRL_WRAP = 7;
    localparam int CTRL_RUN = 6;
    localparam int SETUP_WRAP_EN = 0;
    localparam int PWM_VIEW = 7;
    localparam int PWM_IWRAP = 6;
    localparam int PWM_IWRAP_EN = 5;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] PWM_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;

    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic tick;
        logic [15:0] count;
        logic [15:0] count_nxt;
        logic wrap16;
        logic wrap_len;
        logic [1:0] cycle_len;
        logic view;
    } timebase_t;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync
    import counter_array_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic pin_out
);
    logic [SYNC_STAGES-1:0] stage_ff;
    logic [SYNC_STAGES-1:0] nxt_stage;

    // ----------------------------------------
    // Two stage synchroniser
    // ----------------------------------------
    // two flop sync
    always_comb begin
        nxt_stage = {stage_ff[SYNC_STAGES-2:0], pin_in};
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage_ff <= '0;
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    assign pin_out = stage_ff[SYNC_STAGES-1];
endmodule

// file: capture_compare_channel.sv
`timescale 1ns/1ps
module capture_compare_channel
    import counter_array_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input timebase_t tb_in,
    input wire logic wr_mode_in,
    input wire logic wr_lo_in,
    input wire logic wr_hi_in,
    input wire logic [7:0] wdata_in,
    input wire logic pin_in,
    output logic [7:0] mode_out,
    output logic [15:0] cmp_out,
    output logic event_out,
    output logic pin_out,
    output logic pin_oe_out
);
    logic [7:0] mode_ff, nxt_mode;
    logic [15:0] cmp_ff, nxt_cmp;
    logic [15:0] rld_ff, nxt_rld;
    logic pin_ff, nxt_pin;
    logic oe_ff, nxt_oe;
    logic last_ff;
    logic pin_s;
    logic is_pwm, is_short, is_wide, is_freq, is_tog, is_cap, view_rld;
    logic [15:0] len_mask;
    logic match16, match_lo, match_n;

    pin_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(pin_in),
        .pin_out(pin_s)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always_comb begin
        is_pwm = mode_ff[MODE_PULSE] && !mode_ff[MODE_TOG];
        is_short = is_pwm && !mode_ff[MODE_WIDE];
        is_wide = is_pwm && mode_ff[MODE_WIDE];
        is_freq = mode_ff[MODE_PULSE] && mode_ff[MODE_TOG];
        is_tog = mode_ff[MODE_TOG] && !mode_ff[MODE_PULSE];
        is_cap = (mode_ff[MODE_RISE] || mode_ff[MODE_FALL])
            && (mode_ff[3:1] == 3'b000);
        view_rld = tb_in.view && is_short && (tb_in.cycle_len != 2'b00);
        case (tb_in.cycle_len)
            2'b00: len_mask = 16'h00ff;
            2'b01: len_mask = 16'h01ff;
            2'b10: len_mask = 16'h03ff;
            default: len_mask = 16'h07ff;
        endcase
        match16 = tb_in.tick && (tb_in.count_nxt == cmp_ff);
        match_lo = tb_in.tick && (tb_in.count_nxt[7:0] == cmp_ff[7:0]);
        match_n = tb_in.tick
            && ((tb_in.count_nxt & len_mask) == (cmp_ff & len_mask));
    end

    // ----------------------------------------
    // Channel next state
    // ----------------------------------------
    always_comb begin
        nxt_mode = mode_ff;
        nxt_cmp = cmp_ff;
        nxt_rld = rld_ff;
        nxt_pin = pin_ff;
        event_out = 1'b0;
        if (wr_mode_in) begin
            nxt_mode = wdata_in;
        end
        if (wr_lo_in) begin
            nxt_mode[MODE_CMP_EN] = 1'b0;
            if (view_rld) begin
                nxt_rld[7:0] = wdata_in;
            end else begin
                nxt_cmp[7:0] = wdata_in;
            end
        end
        if (wr_hi_in) begin
            nxt_mode[MODE_CMP_EN] = 1'b1;
            if (view_rld) begin
                nxt_rld[15:8] = wdata_in;
            end else begin
                nxt_cmp[15:8] = wdata_in;
            end
        end
        if (is_cap && ((mode_ff[MODE_RISE] && pin_s && !last_ff)
            || (mode_ff[MODE_FALL] && !pin_s && last_ff))) begin
            nxt_cmp = tb_in.count;
            event_out = 1'b1;
        end
        if (mode_ff[MODE_CMP_EN]) begin
            if (!is_pwm && mode_ff[MODE_MATCH] && match16) begin
                event_out = 1'b1;
            end
            if (is_tog && match16) begin
                nxt_pin = !pin_ff;
            end
            if (is_freq && match_lo) begin
                nxt_pin = !pin_ff;
                nxt_cmp[7:0] = 8'(cmp_ff[7:0] + cmp_ff[15:8]);
            end
            if (is_short) begin
                if (tb_in.wrap_len) begin
                    nxt_pin = 1'b0;
                    if (tb_in.cycle_len == 2'b00) begin
                        nxt_cmp[7:0] = cmp_ff[15:8];
                    end else begin
                        nxt_cmp = rld_ff;
                    end
                end
                if ((tb_in.cycle_len == 2'b00) ? match_lo : match_n) begin
                    nxt_pin = 1'b1;
                    event_out = mode_ff[MODE_MATCH];
                end
            end
            if (is_wide) begin
                if (tb_in.wrap16) begin
                    nxt_pin = 1'b0;
                end
                if (match16) begin
                    nxt_pin = 1'b1;
                    event_out = mode_ff[MODE_MATCH];
                end
            end
        end else if (is_pwm) begin
            nxt_pin = 1'b0;
        end
        nxt_oe = nxt_mode[MODE_PULSE] || nxt_mode[MODE_TOG];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_ff <= MODE_RESET;
            cmp_ff <= CMP_RESET;
            rld_ff <= CMP_RESET;
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            cmp_ff <= nxt_cmp;
            rld_ff <= nxt_rld;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
            last_ff <= pin_s;
        end
    end

    assign mode_out = mode_ff;
    assign cmp_out = view_rld ? rld_ff : cmp_ff;
    assign pin_out = pin_ff;
    assign pin_oe_out = oe_ff;
endmodule

// file: counter_array_capture_compare.sv
`timescale 1ns/1ps
module counter_array_capture_compare
    import counter_array_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input sfr_req_t sfr_req_in,
    input wire logic count_tick_in,
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    input wire logic [NUM_CH-1:0] channel_pin_in,
    output logic [7:0] sfr_rdata_out,
    output logic [NUM_CH-1:0] channel_pin_out,
    output logic [NUM_CH-1:0] channel_pin_oe_out,
    output logic irq_out
);
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] setup_ff, nxt_setup;
    logic [7:0] pwm_ff, nxt_pwm;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [7:0] snap_ff, nxt_snap;
    logic [7:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic [15:0] len_mask;
    timebase_t tb;
    logic [7:0] ch_mode [NUM_CH];
    logic [15:0] ch_cmp [NUM_CH];
    logic [NUM_CH-1:0] ch_event, ch_pin, ch_oe;
    logic [NUM_CH-1:0] wr_mode, wr_lo, wr_hi, ch_irq_en;
    logic [NUM_CH-1:0] nxt_ch_flags;
    logic any_req;

    // ----------------------------------------
    // Shared counter timebase
    // ----------------------------------------
    always_comb begin
        case (pwm_ff[1:0])
            2'b00: len_mask = 16'h00ff;
            2'b01: len_mask = 16'h01ff;
            2'b10: len_mask = 16'h03ff;
            default: len_mask = 16'h07ff;
        endcase
        tb.tick = ctrl_ff[CTRL_RUN] && count_tick_in;
        tb.count = cnt_ff;
        tb.count_nxt = 16'(cnt_ff + 16'h0001);
        tb.wrap16 = tb.tick && (cnt_ff == 16'hffff);
        tb.wrap_len = tb.tick && ((cnt_ff & len_mask) == len_mask);
        tb.cycle_len = pwm_ff[1:0];
        tb.view = pwm_ff[PWM_VIEW];
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            always_comb begin
                wr_mode[i] = sfr_req_in.wr
                    && (sfr_req_in.addr == 4'(ADDR_MODE0 + i));
                wr_lo[i] = sfr_req_in.wr
                    && (sfr_req_in.addr == 4'(ADDR_CMP0 + 2 * i));
                wr_hi[i] = sfr_req_in.wr
                    && (sfr_req_in.addr == 4'(ADDR_CMP0 + 2 * i + 1));
                ch_irq_en[i] = ch_mode[i][MODE_IRQ];
            end
            capture_compare_channel u_ch (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .tb_in(tb),
                .wr_mode_in(wr_mode[i]),
                .wr_lo_in(wr_lo[i]),
                .wr_hi_in(wr_hi[i]),
                .wdata_in(sfr_req_in.wdata),
                .pin_in(channel_pin_in[i]),
                .mode_out(ch_mode[i]),
                .cmp_out(ch_cmp[i]),
                .event_out(ch_event[i]),
                .pin_out(ch_pin[i]),
                .pin_oe_out(ch_oe[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // Flags, control and counter
    // ----------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_setup = setup_ff;
        nxt_pwm = pwm_ff;
        nxt_cnt = tb.tick ? tb.count_nxt : cnt_ff;
        if (sfr_req_in.wr) begin
            if (sfr_req_in.addr == ADDR_CTRL) begin
                nxt_ctrl = ctrl_ff & sfr_req_in.wdata;
                nxt_ctrl[CTRL_RUN] = sfr_req_in.wdata[CTRL_RUN];
            end else if (sfr_req_in.addr == ADDR_SETUP) begin
                nxt_setup = 8'h00;
                nxt_setup[SETUP_WRAP_EN] = sfr_req_in.wdata[SETUP_WRAP_EN];
            end else if (sfr_req_in.addr == ADDR_PWM) begin
                nxt_pwm = sfr_req_in.wdata & 8'ha3;
                nxt_pwm[PWM_IWRAP] = pwm_ff[PWM_IWRAP]
                    && sfr_req_in.wdata[PWM_IWRAP];
            end else if (sfr_req_in.addr == ADDR_CNT_LO) begin
                nxt_cnt[7:0] = sfr_req_in.wdata;
            end else if (sfr_req_in.addr == ADDR_CNT_HI) begin
                nxt_cnt[15:8] = sfr_req_in.wdata;
            end
        end
        if (tb.wrap16) begin
            nxt_ctrl[CTRL_WRAP] = 1'b1;
        end
        if (tb.wrap_len) begin
            nxt_pwm[PWM_IWRAP] = 1'b1;
        end
        nxt_ch_flags = nxt_ctrl[NUM_CH-1:0] | ch_event;
        nxt_ctrl[NUM_CH-1:0] = nxt_ch_flags;
        any_req = (ctrl_ff[CTRL_WRAP] && setup_ff[SETUP_WRAP_EN])
            || (pwm_ff[PWM_IWRAP] && pwm_ff[PWM_IWRAP_EN])
            || |(ctrl_ff[NUM_CH-1:0] & ch_irq_en);
        nxt_irq = any_req && global_irq_enable_in && array_irq_enable_in;
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_snap = snap_ff;
        if (sfr_req_in.rd) begin
            nxt_rdata = 8'h00;
            if (sfr_req_in.addr == ADDR_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (sfr_req_in.addr == ADDR_SETUP) begin
                nxt_rdata = setup_ff;
            end else if (sfr_req_in.addr == ADDR_PWM) begin
                nxt_rdata = pwm_ff;
            end else if (sfr_req_in.addr == ADDR_CNT_LO) begin
                nxt_rdata = cnt_ff[7:0];
                nxt_snap = cnt_ff[15:8];
            end else if (sfr_req_in.addr == ADDR_CNT_HI) begin
                nxt_rdata = snap_ff;
            end else begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (sfr_req_in.addr == 4'(ADDR_MODE0 + i)) begin
                        nxt_rdata = ch_mode[i];
                    end else if (sfr_req_in.addr
                        == 4'(ADDR_CMP0 + 2 * i)) begin
                        nxt_rdata = ch_cmp[i][7:0];
                    end else if (sfr_req_in.addr
                        == 4'(ADDR_CMP0 + 2 * i + 1)) begin
                        nxt_rdata = ch_cmp[i][15:8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_ff <= CTRL_RESET;
            setup_ff <= SETUP_RESET;
            pwm_ff <= PWM_RESET;
            cnt_ff <= CNT_RESET;
            snap_ff <= 8'h00;
            rdata_ff <= 8'h00;
            irq_ff <= 1'b0;
            channel_pin_out <= '0;
            channel_pin_oe_out <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            setup_ff <= nxt_setup;
            pwm_ff <= nxt_pwm;
            cnt_ff <= nxt_cnt;
            snap_ff <= nxt_snap;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            channel_pin_out <= ch_pin;
            channel_pin_oe_out <= ch_oe;
        end
    end

    assign sfr_rdata_out = rdata_ff;
    assign irq_out = irq_ff;
endmodule

// file: counter_array_asserts.sv
`timescale 1ns/1ps
module counter_array_asserts
    import counter_array_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input sfr_req_t sfr_req_in,
    input wire logic count_tick_in,
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    input wire logic [NUM_CH-1:0] channel_pin_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic [NUM_CH-1:0] channel_pin_out,
    input wire logic [NUM_CH-1:0] channel_pin_oe_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ------------------------------
    // Flag snapshot helper
    // ------------------------------
    logic rd_ctl_ff;
    logic seen_ff;
    logic [7:0] prev_ff;
    wire rd_ctl = sfr_req_in.rd && sfr_req_in.addr == ADDR_CTRL;
    wire wr_ctl = sfr_req_in.wr && sfr_req_in.addr == ADDR_CTRL;
    always_ff @(posedge clk_in) begin
        rd_ctl_ff <= rd_ctl && !rst_in;
        if (rst_in || wr_ctl) begin
            seen_ff <= 1'b0;
        end else if (rd_ctl_ff) begin
            seen_ff <= 1'b1;
            prev_ff <= sfr_rdata_out;
        end
    end
    // ------------------------------
    // Assertions
    // ------------------------------
    AST_IRQ_NEEDS_BOTH: assert property (irq_out |->
        $past(global_irq_enable_in) && $past(array_irq_enable_in))
        else $error("irq without both enables");
    AST_IRQ_GLOBAL_OFF: assert property (!global_irq_enable_in
        |=> !irq_out) else $error("irq with global enable off");
    AST_IRQ_ARRAY_OFF: assert property (!array_irq_enable_in
        |=> !irq_out) else $error("irq with array enable off");
    AST_LOW_CLEARS_CMP: assert property ((sfr_req_in.wr &&
        sfr_req_in.addr == ADDR_CMP0) ##1 !sfr_req_in.wr ##1
        (sfr_req_in.rd && sfr_req_in.addr == ADDR_MODE0)
        |=> !sfr_rdata_out[MODE_CMP_EN]) else $error("low write kept enable");
    AST_HIGH_SETS_CMP: assert property ((sfr_req_in.wr &&
        sfr_req_in.addr == ADDR_CMP0 + 4'h1) ##1 !sfr_req_in.wr ##1
        (sfr_req_in.rd && sfr_req_in.addr == ADDR_MODE0)
        |=> sfr_rdata_out[MODE_CMP_EN]) else $error("high write no enable");
    AST_FLAG_STICKY: assert property (rd_ctl_ff && seen_ff |->
        (sfr_rdata_out & prev_ff) == prev_ff)
        else $error("flag cleared without write");
    AST_PWM_RSVD_ZERO: assert property ((sfr_req_in.rd &&
        sfr_req_in.addr == ADDR_PWM) |=> sfr_rdata_out[4:2] == 3'h0)
        else $error("pwm control unused bits set");
    AST_CNT_NO_TICK: assert property ((sfr_req_in.rd &&
        sfr_req_in.addr == ADDR_CNT_LO && !count_tick_in && !sfr_req_in.wr)
        ##1 (!count_tick_in && !sfr_req_in.wr) ##1 (sfr_req_in.rd &&
        sfr_req_in.addr == ADDR_CNT_LO) |=> $stable(sfr_rdata_out))
        else $error("counter moved without tick");
    COV_IRQ: cover property ($rose(irq_out));
    COV_STICKY: cover property (rd_ctl_ff && seen_ff && prev_ff[0]);
    COV_PIN: cover property ($rose(channel_pin_out[0]));
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import counter_array_pkg::*;
    logic clk_in = 0;
    logic rst_in = 1;
    sfr_req_t req = '0;
    logic tick = 0;
    logic gie = 0;
    logic aie = 0;
    logic [2:0] pin = 0;
    logic [7:0] rdata;
    logic [2:0] pout;
    logic [2:0] poe;
    logic irq;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int hi = 0;
    int tog = 0;
    int ch = 0;
    logic [1:0] td = 0;
    logic [2:0] last = 0;
    logic [31:0] seed = 32'h00002339;
    logic [7:0] v;
    logic [7:0] lo;
    logic [7:0] hb;
    logic [15:0] c;
    int n;

    counter_array_capture_compare i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .sfr_req_in(req), .count_tick_in(tick),
        .global_irq_enable_in(gie), .array_irq_enable_in(aie),
        .channel_pin_in(pin), .sfr_rdata_out(rdata),
        .channel_pin_out(pout), .channel_pin_oe_out(poe), .irq_out(irq));

    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // ------------------------------
    // Monitor and timeout
    // ------------------------------
    always @(posedge clk_in) begin
        cyc++;
        td <= {td[0], tick};
        if (td[1] && pout[ch] === 1'b1) hi++;
        if (pout[ch] !== last[ch]) tog++;
        last <= pout;
        if (cyc == 30000) begin
            failures++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(logic w, logic [3:0] a, logic [7:0] d);
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk_in);
        req <= '0;
        @(posedge clk_in);
        v = rdata;
    endtask
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd_reg(logic [3:0] a);
        acc(1'b0, a, 8'h00);
    endtask
    task automatic idle(int k);
        repeat (k) @(posedge clk_in);
    endtask
    task automatic run(int k);
        tick <= 1'b1;
        idle(k);
        tick <= 1'b0;
        idle(4);
    endtask
    task automatic setcnt(logic [15:0] x);
        wr_reg(ADDR_CNT_LO, x[7:0]);
        wr_reg(ADDR_CNT_HI, x[15:8]);
    endtask
    task automatic setcmp(int k, logic [15:0] x);
        wr_reg(ADDR_CMP0 + 4'(2 * k), x[7:0]);
        wr_reg(ADDR_CMP0 + 4'(2 * k + 1), x[15:8]);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        idle(8);
        rst_in <= 1'b0;
        idle(1);
        // ------------------------------
        // Reset values and unmapped place
        // ------------------------------
        for (int a = 0; a < 14; a++) begin
            rd_reg(4'(a));
            chk("reset value", 16'h0000, {8'h00, v});
        end
        rd_reg(ADDR_CNT_LO);
        wr_reg(4'he, 8'(rnd()));
        rd_reg(4'he);
        chk("unmapped", 16'h0000, {8'h00, v});
        wr_reg(ADDR_CTRL, 8'h40);
        gie <= 1'b1;
        // ------------------------------
        // Compare bytes, timer match, wrap, irq tree
        // ------------------------------
        for (int k = 0; k < 3; k++) begin
            lo = (k == 1) ? 8'h0d : 8'h09;
            wr_reg(ADDR_MODE0 + 4'(k), lo);
            c = {8'hff, 8'(8'hf1 + rnd() % 8)};
            wr_reg(ADDR_CMP0 + 4'(2 * k), c[7:0]);
            rd_reg(ADDR_MODE0 + 4'(k));
            chk("enable after low", 16'h0000, {15'h0, v[6]});
            wr_reg(ADDR_CMP0 + 4'(2 * k + 1), c[15:8]);
            rd_reg(ADDR_MODE0 + 4'(k));
            chk("mode after high", {8'h00, lo | 8'h40}, {8'h00, v});
            rd_reg(ADDR_CMP0 + 4'(2 * k));
            lo = v;
            rd_reg(ADDR_CMP0 + 4'(2 * k + 1));
            chk("compare value", c, {v, lo});
            setcnt(16'hfff0);
            wr_reg(ADDR_CTRL, 8'h40);
            ch = k;
            tog = 0;
            run(20);
            chk("toggles on match", 16'(k == 1), 16'(tog));
            rd_reg(ADDR_CTRL);
            n = 8'hc0 | (8'h01 << k);
            chk("match and wrap", 16'(n), {8'h00, v});
            chk("irq array off", 16'h0000, {15'h0, irq});
            aie <= 1'b1;
            idle(3);
            chk("irq channel", 16'h0001, {15'h0, irq});
            wr_reg(ADDR_CTRL, 8'hc0);
            idle(2);
            chk("irq after clear", 16'h0000, {15'h0, irq});
            rd_reg(ADDR_CTRL);
            chk("flags after clear", 16'h00c0, {8'h0, v});
            wr_reg(ADDR_SETUP, 8'h01);
            idle(2);
            chk("irq wrap", 16'h0001, {15'h0, irq});
            gie <= 1'b0;
            idle(3);
            chk("irq global off", 16'h0000, {15'h0, irq});
            gie <= 1'b1;
            aie <= 1'b0;
            wr_reg(ADDR_SETUP, 8'h00);
            wr_reg(ADDR_CTRL, 8'h40);
            wr_reg(ADDR_MODE0 + 4'(k), 8'h00);
        end
        // ------------------------------
        // Intermediate wrap for each length
        // ------------------------------
        for (int len = 0; len < 4; len++) begin
            wr_reg(ADDR_PWM, 8'(len));
            setcnt(16'((1 << (8 + len)) - 4));
            run(8);
            rd_reg(ADDR_PWM);
            chk("intermediate", 16'(8'h40 | len), {8'h0, v});
            rd_reg(ADDR_CTRL);
            chk("no main wrap", 16'h0040, {8'h0, v});
            aie <= 1'b1;
            wr_reg(ADDR_PWM, 8'(8'h60 | len));
            idle(2);
            chk("irq intermediate", 16'h0001, {15'h0, irq});
            aie <= 1'b0;
            wr_reg(ADDR_PWM, 8'h00);
        end
        // ------------------------------
        // Edge capture modes
        // ------------------------------
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h20 : (k == 1) ? 8'h10 : 8'h30;
            lo = v;
            wr_reg(ADDR_MODE0 + 4'(k), lo);
            for (int e = 0; e < 2; e++) begin
                c = 16'(rnd());
                setcnt(c);
                rd_reg(ADDR_CNT_LO);
                rd_reg(ADDR_CNT_LO);
                hb = v;
                rd_reg(ADDR_CNT_HI);
                chk("counter", c, {v, hb});
                wr_reg(ADDR_CTRL, 8'h40);
                pin[k] <= !e[0];
                idle(8);
                rd_reg(ADDR_CTRL);
                n = e ? lo[4] : lo[5];
                chk("capture flag", 16'(n), {15'h0, v[k]});
                rd_reg(ADDR_CMP0 + 4'(2 * k + 1));
                hb = v;
                rd_reg(ADDR_CMP0 + 4'(2 * k));
                if (n == 1) chk("captured", c, {hb, v});
            end
            wr_reg(ADDR_MODE0 + 4'(k), 8'h00);
        end
        wr_reg(ADDR_CTRL, 8'h40);
        // ------------------------------
        // Frequency output
        // ------------------------------
        for (int t = 0; t < 3; t++) begin
            ch = rnd() % 3;
            c = {(t == 0) ? 8'h00 : (t == 1) ? 8'h01 : 8'(rnd()), 8'(rnd())};
            wr_reg(ADDR_MODE0 + 4'(ch), 8'h06);
            setcmp(ch, c);
            setcnt(16'h0000);
            tog = 0;
            run(600);
            n = (c[7:0] == 0) ? 256 : c[7:0];
            hi = (c[15:8] == 0) ? 256 : c[15:8];
            n = (600 >= n) ? 1 + (600 - n) / hi : 0;
            chk("toggles", 16'(n), 16'(tog));
            chk("pin driven", 16'h0001, {15'h0, poe[ch]});
            wr_reg(ADDR_CMP0 + 4'(2 * ch), 8'(rnd()));
            setcnt(16'h0000);
            tog = 0;
            run(600);
            chk("held pin", 16'h0000, 16'(tog));
            wr_reg(ADDR_MODE0 + 4'(ch), 8'h00);
        end
        // ------------------------------
        // Pulse width modes
        // ------------------------------
        for (int t = 0; t < 3; t++) begin
            ch = rnd() % 3;
            lo = 8'(1 + rnd() % 255);
            wr_reg(ADDR_PWM, (t == 1) ? 8'h03 : 8'h00);
            wr_reg(ADDR_MODE0 + 4'(ch), (t == 1) ? 8'hc2 : 8'h42);
            setcmp(ch, (t == 1) ? {8'hfe, lo} : {lo, lo});
            if (t == 2) wr_reg(ADDR_CMP0 + 4'(2 * ch), lo);
            setcnt((t == 1) ? 16'hfe00 : 16'h0000);
            hi = 0;
            run(512);
            n = (t == 2) ? 0 : (t == 1) ? 512 - lo : 2 * (256 - lo);
            chk("high cycles", 16'(n), 16'(hi));
            wr_reg(ADDR_MODE0 + 4'(ch), 8'h00);
        end
        // ------------------------------
        // Reload view routing
        // ------------------------------
        wr_reg(ADDR_PWM, 8'h81);
        wr_reg(ADDR_MODE0, 8'h42);
        setcmp(0, 16'h0123);
        rd_reg(ADDR_CMP0);
        hb = v;
        rd_reg(ADDR_CMP0 + 4'h1);
        chk("reload view", 16'h0123, {v, hb});
        print_verdict();
    end
endmodule

bind counter_array_capture_compare counter_array_asserts i_chk (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_req_in(sfr_req_in),
    .count_tick_in(count_tick_in),
    .global_irq_enable_in(global_irq_enable_in),
    .array_irq_enable_in(array_irq_enable_in),
    .channel_pin_in(channel_pin_in), .sfr_rdata_out(sfr_rdata_out),
    .channel_pin_out(channel_pin_out),
    .channel_pin_oe_out(channel_pin_oe_out), .irq_out(irq_out));
